// ===== comparator_control_irq.v
`timescale 1ns/1ps
`default_nettype none
`include "comparator_map.vh"
module comparator_control_irq #(
  parameter ADDR_WIDTH = 12
) (
  input wire clk_i, // peripheral clock
  input wire reset_n_i, // synchronous reset, active low
  input wire psel_i, // apb select
  input wire penable_i, // apb enable
  input wire pwrite_i, // apb write
  input wire [ADDR_WIDTH-1:0] paddr_i, // apb byte address
  input wire [31:0] pwdata_i, // apb write data
  input wire [3:0] pstrb_i, // apb byte strobes
  output reg [31:0] prdata_o, // apb read data
  output reg pready_o, // apb ready
  output reg pslverr_o, // apb error for unmapped address
  input wire raw_compare_i, // analog front end raw result
  input wire [1:0] sleep_mode_i, // system sleep state
  input wire clock_request_i, // another module keeps the clock running
  output reg analog_enable_o, // front end powered
  output reg [1:0] hysteresis_select_o, // hysteresis level
  output reg positive_input_select_o, // positive mux
  output reg [1:0] negative_input_select_o, // negative mux
  output reg vref_request_o, // internal reference requested
  output reg low_power_o, // low-power bias
  output reg pad_output_enable_o, // pad driver on
  output wire event_o, // asynchronous event output
  output reg pad_o, // pad data
  output reg irq_o // interrupt request
);
  // ************************************************************
  // registers
  // ************************************************************
  reg enable;
  reg [1:0] hysteresis_select;
  reg [1:0] edge_mode_select;
  reg pad_output_enable;
  reg run_in_standby;
  reg low_power;
  reg [1:0] negative_input_select;
  reg positive_input_select;
  reg invert;
  reg compare_interrupt_bit;
  wire flag;
  wire state_sync;
  wire [ADDR_WIDTH-1:0] a_main = `ADDR_MAIN_CONTROL;
  wire [ADDR_WIDTH-1:0] a_mux = `ADDR_INPUT_SELECT_CONTROL;
  wire [ADDR_WIDTH-1:0] a_int = `ADDR_INTERRUPT_CONTROL;
  wire [ADDR_WIDTH-1:0] a_stat = `ADDR_STATUS;

  // ************************************************************
  // sleep qualification
  // ************************************************************
  // no debug-halt input exists on purpose: behaviour is identical in halt
  wire in_standby = (sleep_mode_i == `SLEEP_STANDBY);
  wire in_powerdown = (sleep_mode_i == `SLEEP_POWERDOWN);
  // idle and active are treated alike
  wire running = enable & ~in_powerdown & (~in_standby | run_in_standby);
  // in standby the status only moves if someone else holds the clock on
  wire status_update = ~in_standby | clock_request_i;

  // ************************************************************
  // result path
  // ************************************************************
  // front end gives 1 when positive exceeds negative
  // inversion precedes every consumer; no event input exists
  // the event path stays combinational so it reaches the event network unclocked
  assign event_o = running & (raw_compare_i ^ invert);

  level_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(raw_compare_i),
    .sync_o(state_sync)
  );

  // the raw pin is synchronised bare, so no clocked logic sees it before two flops; only event_o takes it directly
  // an unpowered front end only gives noise, so clocked consumers see 0 until it runs
  wire result_sync = running & (state_sync ^ invert);

  // the state bit is registered once more, making three cycles
  reg state_bit;
  always @(posedge clk_i) begin
    if (!reset_n_i)
      state_bit <= 1'b0;
    else if (status_update)
      state_bit <= result_sync;
  end

  // writes land on the edge where the master sees pready, exactly once per transfer
  wire bus_write = psel_i & penable_i & pwrite_i & pready_o;
  wire clear_flag = bus_write & (paddr_i == a_stat) & pstrb_i[0] & pwdata_i[`BIT_FLAG];

  // edge detection on synchronised samples
  edge_flag u_edge (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .level_i(result_sync),
    .mode_i(edge_mode_select),
    .update_i(running & status_update),
    .clear_i(clear_flag),
    .flag_o(flag)
  );

  // ************************************************************
  // register writes
  // ************************************************************
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      enable <= 1'b0;
      hysteresis_select <= 2'h0;
      edge_mode_select <= 2'h0;
      pad_output_enable <= 1'b0;
      run_in_standby <= 1'b0;
      low_power <= 1'b0;
      negative_input_select <= 2'h0;
      positive_input_select <= 1'b0;
      invert <= 1'b0;
      compare_interrupt_bit <= 1'b0;
    end else if (bus_write) begin
      if (paddr_i == a_main) begin
        if (pstrb_i[0]) begin
          enable <= pwdata_i[`BIT_ENABLE];
          hysteresis_select <= pwdata_i[`BIT_HYST_LO +: 2];
          edge_mode_select <= pwdata_i[`BIT_EDGE_LO +: 2];
          pad_output_enable <= pwdata_i[`BIT_PAD_OUTPUT_ENABLE];
          run_in_standby <= pwdata_i[`BIT_RUN_IN_STANDBY];
        end
        if (pstrb_i[1])
          low_power <= pwdata_i[`BIT_LOW_POWER];
      end
      if ((paddr_i == a_mux) && pstrb_i[0]) begin
        negative_input_select <= pwdata_i[`BIT_NEG_SEL_LO +: 2];
        positive_input_select <= pwdata_i[`BIT_POS_SEL];
        invert <= pwdata_i[`BIT_INVERT];
      end
      if ((paddr_i == a_int) && pstrb_i[0])
        compare_interrupt_bit <= pwdata_i[0];
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      analog_enable_o <= 1'b0;
      hysteresis_select_o <= 2'h0;
      positive_input_select_o <= 1'b0;
      negative_input_select_o <= 2'h0;
      vref_request_o <= 1'b0;
      low_power_o <= 1'b0;
      pad_output_enable_o <= 1'b0;
      pad_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      analog_enable_o <= running;
      hysteresis_select_o <= hysteresis_select;
      positive_input_select_o <= positive_input_select;
      negative_input_select_o <= negative_input_select;
      vref_request_o <= running & (negative_input_select == `NEG_VREF);
      low_power_o <= low_power;
      // pad carries the synchronised result; gated off in power-down
      pad_output_enable_o <= pad_output_enable & running;
      pad_o <= result_sync;
      // interrupt is the flag masked by its enable bit; only setting the flag waits for the clock in standby
      irq_o <= compare_interrupt_bit & flag;
    end
  end

  // ************************************************************
  // apb read and answer
  // ************************************************************
  reg [31:0] next_rdata;
  reg mapped;
  always @* begin
    next_rdata = 32'h00000000;
    mapped = 1'b1;
    if (paddr_i == a_main) begin
      next_rdata[`BIT_ENABLE] = enable;
      next_rdata[`BIT_HYST_LO +: 2] = hysteresis_select;
      next_rdata[`BIT_EDGE_LO +: 2] = edge_mode_select;
      next_rdata[`BIT_PAD_OUTPUT_ENABLE] = pad_output_enable;
      next_rdata[`BIT_RUN_IN_STANDBY] = run_in_standby;
      next_rdata[`BIT_LOW_POWER] = low_power;
    end else if (paddr_i == a_mux) begin
      next_rdata[`BIT_NEG_SEL_LO +: 2] = negative_input_select;
      next_rdata[`BIT_POS_SEL] = positive_input_select;
      next_rdata[`BIT_INVERT] = invert;
    end else if (paddr_i == a_int) begin
      next_rdata[0] = compare_interrupt_bit;
    end else if (paddr_i == a_stat) begin
      next_rdata[`BIT_FLAG] = flag;
      next_rdata[`BIT_STATE] = state_bit;
    end else begin
      mapped = 1'b0;
    end
  end

  // one wait state: setup, access with pready low, then pready high
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= ~mapped;
      prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
  end
endmodule // comparator_control_irq
`default_nettype wire

// ===== comparator_map.vh
`ifndef COMPARATOR_MAP_VH
`define COMPARATOR_MAP_VH
// ************************************************************
// register indices; each register is one word, byte address is four times the index
// ************************************************************
`define IDX_MAIN_CONTROL 12'h000
`define IDX_INPUT_SELECT_CONTROL 12'h002
`define IDX_INTERRUPT_CONTROL 12'h006
`define IDX_STATUS 12'h007
`define ADDR_MAIN_CONTROL (`IDX_MAIN_CONTROL << 2)
`define ADDR_INPUT_SELECT_CONTROL (`IDX_INPUT_SELECT_CONTROL << 2)
`define ADDR_INTERRUPT_CONTROL (`IDX_INTERRUPT_CONTROL << 2)
`define ADDR_STATUS (`IDX_STATUS << 2)
// ************************************************************
// main control fields
// ************************************************************
`define BIT_ENABLE 0
`define BIT_HYST_LO 1
`define BIT_EDGE_LO 4
`define BIT_PAD_OUTPUT_ENABLE 6
`define BIT_RUN_IN_STANDBY 7
`define BIT_LOW_POWER 8
// ************************************************************
// input select fields
// ************************************************************
`define BIT_NEG_SEL_LO 0
`define BIT_POS_SEL 3
`define BIT_INVERT 7
// ************************************************************
// status fields
// ************************************************************
`define BIT_FLAG 0
`define BIT_STATE 4
// ************************************************************
// encodings
// ************************************************************
`define EDGE_BOTH 2'h0
`define EDGE_FALL 2'h2
`define EDGE_RISE 2'h3
`define NEG_PIN 2'h0
`define NEG_VREF 2'h2
`define SLEEP_ACTIVE 2'h0
`define SLEEP_IDLE 2'h1
`define SLEEP_STANDBY 2'h2
`define SLEEP_POWERDOWN 2'h3
`define RESET_BYTE 8'h00
`endif

// ===== level_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a level from outside the clock domain
module level_sync (
  input wire clk_i, // clock
  input wire reset_n_i, // synchronous reset, active low
  input wire async_i, // asynchronous level
  output reg sync_o // synchronised level
);
  reg meta;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // level_sync
`default_nettype wire

// ===== edge_flag.v
`timescale 1ns/1ps
`default_nettype none
`include "comparator_map.vh"
// sticky flag set on a selected edge of a synchronised level
module edge_flag (
  input wire clk_i, // clock
  input wire reset_n_i, // synchronous reset, active low
  input wire level_i, // synchronised level
  input wire [1:0] mode_i, // edge selection
  input wire update_i, // flag updates allowed
  input wire clear_i, // clear request
  output reg flag_o // sticky flag
);
  reg prev;
  reg hit;
  always @* begin
    case (mode_i)
      `EDGE_BOTH: hit = level_i ^ prev;
      `EDGE_FALL: hit = prev & ~level_i;
      `EDGE_RISE: hit = ~prev & level_i;
      default: hit = 1'b0;
    endcase
  end
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      prev <= 1'b0;
      flag_o <= 1'b0;
    end else begin
      prev <= level_i;
      // a new edge wins over a clear in the same cycle
      if (update_i && hit)
        flag_o <= 1'b1;
      else if (clear_i)
        flag_o <= 1'b0;
    end
  end
endmodule // edge_flag
`default_nettype wire

// ===== analog_front_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "comparator_map.vh"
module analog_front_model #(
  parameter logic [15:0] VREF_MV = 16'h04B0
) (
  input wire logic clk_i, // clock, only to scramble the idle output
  input wire logic analog_enable_i, // front end powered
  input wire logic [1:0] negative_input_select_i, // negative mux
  input wire logic [15:0] pos_mv_i, // positive pin level, millivolts
  input wire logic [15:0] neg_mv_i, // negative pin level, millivolts
  output logic raw_o // raw compare result
);
  logic [15:0] neg_level;
  logic idle_t = 1'b0;
  always @(posedge clk_i) idle_t <= ~idle_t;
  // the pins reach only the analog compare here, never a digital input buffer
  assign neg_level = (negative_input_select_i == `NEG_VREF) ? VREF_MV : neg_mv_i;
  // an unpowered front end gives nothing usable, so it changes every cycle
  assign raw_o = analog_enable_i ? (pos_mv_i > neg_level) : idle_t;
endmodule // analog_front_model
`default_nettype wire

// ===== comparator_control_irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module comparator_control_irq_checker #(
  parameter ADDR_WIDTH = 12
) (
  input wire logic clk_i, // clock
  input wire logic reset_n_i, // reset, active low
  input wire logic psel_i, // select
  input wire logic penable_i, // enable
  input wire logic pready_o, // ready
  input wire logic raw_compare_i, // raw result
  input wire logic [1:0] sleep_mode_i, // sleep state
  input wire logic analog_enable_o, // front end on
  input wire logic vref_request_o, // reference request
  input wire logic pad_output_enable_o, // pad driver
  input wire logic event_o, // event
  input wire logic pad_o, // pad data
  input wire logic irq_o // interrupt
);
  // ****
  // bus, gating and flag causes
  // ****
  logic raw_q;
  logic [3:0] quiet;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_access; psel_i && penable_i && !pready_o; endsequence
  // a new flag needs a bus access or a raw change a few cycles before
  always @(posedge clk_i) begin
    raw_q <= raw_compare_i;
    if (!reset_n_i || psel_i || raw_q != raw_compare_i) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end
  a_one_wait: assert property (s_setup ##1 s_access |=> pready_o)
    else $error("no ready after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_irq_clear: assert property ($fell(irq_o) |-> $past(psel_i) || $past(psel_i, 2))
    else $error("interrupt dropped without a write");
  a_powerdown_off: assert property ((sleep_mode_i == 2'h3) [*2] |->
    !(analog_enable_o || pad_output_enable_o || event_o || pad_o)) else $error("active in power-down");
  a_vref_running: assert property (vref_request_o |-> analog_enable_o)
    else $error("reference requested while off");
  a_pad_running: assert property (pad_output_enable_o || pad_o |-> analog_enable_o)
    else $error("pad driven while off");
  a_event_tracks: assert property (analog_enable_o && $past(analog_enable_o) && !pready_o
    && !$past(pready_o) && $changed(raw_compare_i) |-> $changed(event_o)) else $error("event stale");
  a_flag_cause: assert property ($rose(irq_o) |-> quiet < 4'h8)
    else $error("interrupt with no cause");
endmodule // comparator_control_irq_checker
bind comparator_control_irq comparator_control_irq_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_checker (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
  .raw_compare_i(raw_compare_i), .sleep_mode_i(sleep_mode_i), .analog_enable_o(analog_enable_o),
  .vref_request_o(vref_request_o), .pad_output_enable_o(pad_output_enable_o), .event_o(event_o),
  .pad_o(pad_o), .irq_o(irq_o));
`default_nettype wire

// ===== comparator_control_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "comparator_map.vh"
module comparator_control_irq_tb;
  localparam logic [15:0] VREF_MV = 16'h04B0;
  localparam int STARTUP_WAIT = 63; // 2.5 us of start-up at 40 ns
  localparam int VREF_WAIT = 1500; // 60 us of reference start-up at 40 ns
  logic [3:0] strb = 4'hF;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic creq = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [11:0] regs [4] = '{`ADDR_MAIN_CONTROL, `ADDR_INPUT_SELECT_CONTROL, `ADDR_INTERRUPT_CONTROL, `ADDR_STATUS};
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, seed = 32'hA3D8;
  logic [1:0] sleep = 2'h0, hyst, neg_sel;
  logic [15:0] pos_mv = 16'h0064, neg_mv = 16'h0064;
  logic pready_o, pslverr_o, slv, raw, an_en, lowp, vref_req, pad_oe, ev, pad, irq, e, pos_sel;
  int err_count = 0, checked = 0;
  always #20 clk_i = ~clk_i;
  comparator_control_irq u_comparator_control_irq (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(strb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .raw_compare_i(raw), .sleep_mode_i(sleep),
    .clock_request_i(creq), .analog_enable_o(an_en), .hysteresis_select_o(hyst), .positive_input_select_o(pos_sel),
    .negative_input_select_o(neg_sel), .vref_request_o(vref_req), .low_power_o(lowp),
    .pad_output_enable_o(pad_oe), .event_o(ev), .pad_o(pad), .irq_o(irq));
  analog_front_model #(.VREF_MV(VREF_MV)) u_analog_front_model (.clk_i(clk_i), .analog_enable_i(an_en),
    .negative_input_select_i(neg_sel), .pos_mv_i(pos_mv), .neg_mv_i(neg_mv), .raw_o(raw));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic exp_cmp(input logic [11:0] p, input logic [11:0] n);
    return p > n;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    rd = prdata_o;
    slv = pslverr_o;
    if (n >= 40) err_count++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    err_count++;
    complete_run();
  end
  initial begin
    cyc(3);
    reset_n_i <= 1'b1;
    cyc(1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, regs[i], 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 12'h004, 32'h0);
    check({rd[30:0], slv}, 32'h1);
    strb <= 4'h0;
    apb(1'b1, `ADDR_MAIN_CONTROL, 32'h000001FF);
    strb <= 4'hF;
    apb(1'b0, `ADDR_MAIN_CONTROL, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `ADDR_INPUT_SELECT_CONTROL, 32'hFFFFFF8B);
    apb(1'b0, `ADDR_INPUT_SELECT_CONTROL, 32'h0);
    check(rd, 32'h8B);
    check({31'h0, pos_sel}, 32'h1);
    $display("reset test done");
    apb(1'b1, `ADDR_INPUT_SELECT_CONTROL, 32'h0);
    apb(1'b1, `ADDR_INTERRUPT_CONTROL, 32'h1);
    for (int m = 0; m < 4; m++) begin
      pos_mv <= 16'h0032;
      apb(1'b1, `ADDR_MAIN_CONTROL, 32'h41 | (m << 4) | (m << 1) | ((m & 1) << 8));
      check({30'h0, hyst}, m);
      check({31'h0, lowp}, m & 1);
      cyc(STARTUP_WAIT);
      apb(1'b1, `ADDR_STATUS, 32'h1);
      pos_mv <= 16'h00C8;
      cyc(6);
      check({30'h0, pad, ev}, 32'h3);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check(rd, {27'h0, 1'b1, 3'h0, m == 0 || m == 3});
      apb(1'b1, `ADDR_STATUS, 32'h0);
      check({31'h0, irq}, m == 0 || m == 3);
      apb(1'b1, `ADDR_STATUS, 32'h1);
      check({31'h0, irq}, 32'h0);
      pos_mv <= 16'h0032;
      cyc(6);
      check({31'h0, irq}, m == 0 || m == 2);
    end
    apb(1'b1, `ADDR_INPUT_SELECT_CONTROL, 32'h80);
    cyc(4);
    check({30'h0, pad, ev}, 32'h3);
    apb(1'b1, `ADDR_INPUT_SELECT_CONTROL, {30'h0, `NEG_VREF});
    pos_mv <= VREF_MV + 16'h0001;
    cyc(VREF_WAIT);
    check({30'h0, vref_req, ev}, 32'h3);
    $display("edge and input test done");
    apb(1'b1, `ADDR_INPUT_SELECT_CONTROL, 32'h0);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      pos_mv <= {4'h0, seed[11:0]};
      neg_mv <= (i == 0) ? {4'h0, seed[11:0]} : {4'h0, seed[27:16]};
      e = exp_cmp(seed[11:0], (i == 0) ? seed[11:0] : seed[27:16]);
      cyc(4);
      check({30'h0, pad, ev}, {30'h0, e, e});
    end
    $display("random compare test done");
    pos_mv <= 16'h00C8;
    neg_mv <= 16'h0064;
    cyc(1);
    sleep <= `SLEEP_POWERDOWN;
    cyc(3);
    check({29'h0, an_en, pad_oe, ev}, 32'h0);
    sleep <= `SLEEP_IDLE;
    cyc(3);
    check({29'h0, an_en, pad_oe, ev}, 32'h7);
    sleep <= `SLEEP_STANDBY;
    cyc(3);
    check({31'h0, an_en}, 32'h0);
    sleep <= `SLEEP_IDLE;
    apb(1'b1, `ADDR_INTERRUPT_CONTROL, 32'h0);
    apb(1'b1, `ADDR_MAIN_CONTROL, 32'hC1);
    cyc(6);
    apb(1'b1, `ADDR_STATUS, 32'h1);
    sleep <= `SLEEP_STANDBY;
    pos_mv <= 16'h0032;
    cyc(6);
    check({28'h0, an_en, pad_oe, pad, ev}, 32'hC);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(rd, 32'h10);
    creq <= 1'b1;
    cyc(6);
    apb(1'b1, `ADDR_STATUS, 32'h1);
    pos_mv <= 16'h00C8;
    cyc(6);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(rd, 32'h11);
    $display("sleep test done");
    complete_run();
  end
endmodule // comparator_control_irq_tb
`default_nettype wire
